//--- logic/accessory_detect_status_irq.sv
`timescale 1ns/1ns
`include "accdet_regs.svh"

module accessory_detect_status_irq
  import accdet_pkg::*;
#(
  parameter int ADC_W = 8
) (
  // clock, reset, enable
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // register port from the serial control block
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  // jack front end, asynchronous
  input  wire logic              jack_present_i,
  input  wire logic              hptest_comp_i,
  // measurement results, same clock
  input  wire logic              mic_meas_valid_i,
  input  wire logic [10:0]       mic_impedance_i,
  input  wire logic              order_meas_valid_i,
  input  wire logic              order_meas_i,
  input  wire logic              adc_valid_i,
  input  wire logic [ADC_W-1:0]  adc_sample_i,
  input  wire logic [7:0]        button_event_i,
  // controls out to the analog side
  output logic                   micbias_en_o,
  output logic                   type_meas_start_o,
  output logic                   order_meas_start_o,
  output logic [7:0]             config_one_o,
  output logic [7:0]             config_two_o,
  output logic [7:0]             force_sampling_o,
  output logic [7:0]             hptest_ctrl_o,
  output logic [7:0]             thr_first_o,
  output logic [7:0]             thr_second_o,
  output logic [7:0]             thr_third_o,
  output logic [7:0]             thr_mic_o,
  // interrupt
  output logic                   irq_o
);

  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (ADC_W != 8) begin : g_bad_width
    $error("ADC_W must be 8 to fit the impedance status byte");
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // change accepted only once stages two and three agree
  // bounces shorter than two cycles never reach the detector
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] sync3_reg;
  logic [1:0] pin_reg;
  logic [1:0] pin_raw;

  assign pin_raw = {hptest_comp_i, jack_present_i};

  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_sync
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        sync1_reg[gi] <= 1'b0;
        sync2_reg[gi] <= 1'b0;
        sync3_reg[gi] <= 1'b0;
        pin_reg[gi]   <= 1'b0;
      end else if (ce_i) begin
        sync1_reg[gi] <= pin_raw[gi];
        sync2_reg[gi] <= sync1_reg[gi];
        sync3_reg[gi] <= sync2_reg[gi];
        if (sync2_reg[gi] == sync3_reg[gi]) begin
          pin_reg[gi] <= sync3_reg[gi];
        end
      end
    end
  end

  wire present_now = pin_reg[0];
  wire comp_now    = pin_reg[1];

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg_byte_t cfg1_reg, cfg2_reg, cfg7_reg, cfg8_reg;
  reg_byte_t thr1_reg, thr2_reg, thr3_reg, thr4_reg;
  reg_byte_t jmask_reg, bmask_reg, bflag_reg, imp_reg;
  logic [`JACK_EVT_W-1:0] jflag_reg;
  logic [`JACK_EVT_W-1:0] jflag_next;
  reg_byte_t              bflag_next;
  logic present_reg, type_reg, order_reg, bias_reg;
  logic present_seen_reg;
  det_state_t state_reg, state_next;

  wire wr_cfg1  = reg_wr_i && (reg_addr_i == `DETECT_CONFIG_ONE_ADDR);
  wire wr_cfg2  = reg_wr_i && (reg_addr_i == `DETECT_CONFIG_TWO_ADDR);
  wire wr_cfg7  = reg_wr_i && (reg_addr_i == `DETECT_FORCE_SAMP_ADDR);
  wire wr_cfg8  = reg_wr_i && (reg_addr_i == `HP_TEST_CONTROL_ADDR);
  wire wr_thr1  = reg_wr_i && (reg_addr_i == `BUTTON_THR_FIRST_ADDR);
  wire wr_thr2  = reg_wr_i && (reg_addr_i == `BUTTON_THR_SECOND_ADDR);
  wire wr_thr3  = reg_wr_i && (reg_addr_i == `BUTTON_THR_THIRD_ADDR);
  wire wr_thr4  = reg_wr_i && (reg_addr_i == `BUTTON_THR_MIC_ADDR);
  wire wr_jmask = reg_wr_i && (reg_addr_i == `JACK_EVENT_MASKS_ADDR);
  wire wr_bmask = reg_wr_i && (reg_addr_i == `BUTTON_EVENT_MASKS_ADDR);
  wire wr_jflag = reg_wr_i && (reg_addr_i == `JACK_EVENT_FLAGS_ADDR);
  wire wr_bflag = reg_wr_i && (reg_addr_i == `BUTTON_EVENT_FLAGS_ADDR);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cfg1_reg  <= `CONFIG_ONE_RESET;
      cfg2_reg  <= `REG_ZERO_RESET;
      cfg7_reg  <= `REG_ZERO_RESET;
      cfg8_reg  <= `REG_ZERO_RESET;
      thr1_reg  <= `REG_ZERO_RESET;
      thr2_reg  <= `REG_ZERO_RESET;
      thr3_reg  <= `REG_ZERO_RESET;
      thr4_reg  <= `REG_ZERO_RESET;
      jmask_reg <= `REG_ZERO_RESET;
      bmask_reg <= `REG_ZERO_RESET;
    end else if (ce_i) begin
      if (wr_cfg1)  cfg1_reg  <= reg_wdata_i;
      if (wr_cfg2)  cfg2_reg  <= reg_wdata_i;
      if (wr_cfg7)  cfg7_reg  <= reg_wdata_i;
      if (wr_cfg8)  cfg8_reg  <= reg_wdata_i & `CFG8_WMASK;
      if (wr_thr1)  thr1_reg  <= reg_wdata_i;
      if (wr_thr2)  thr2_reg  <= reg_wdata_i;
      if (wr_thr3)  thr3_reg  <= reg_wdata_i;
      if (wr_thr4)  thr4_reg  <= reg_wdata_i;
      // reserved mask bits dropped so they read back 0
      if (wr_jmask) jmask_reg <= {5'h00, reg_wdata_i[`JACK_EVT_W-1:0]};
      if (wr_bmask) bmask_reg <= reg_wdata_i;
    end
  end

  // ------------------------------------------------------------
  // detection sequence
  // ------------------------------------------------------------
  wire det_enable  = cfg1_reg[`CFG1_ENABLE_BIT];
  wire type_det_en = cfg1_reg[`CFG1_TYPE_DET_BIT];
  wire ordr_det_en = cfg1_reg[`CFG1_ORDER_DET_BIT];
  wire [1:0] thr_sel = cfg1_reg[`CFG1_THRESH_LSB +: 2];
  // a plug left in while disabled is seen once enabled
  wire insert_evt  = present_now && !present_seen_reg && det_enable;
  wire remove_evt  = !present_now && present_seen_reg;

  logic [10:0] mic_thresh;
  assign mic_thresh = (thr_sel == 2'b00) ? `MIC_THRESH_200 :
                      (thr_sel == 2'b01) ? `MIC_THRESH_500 :
                      (thr_sel == 2'b10) ? `MIC_THRESH_750 : `MIC_THRESH_1000;

  // equal to threshold counts as 3-pole, keeps a floating mic off bias
  wire type_meas   = (mic_impedance_i > mic_thresh);
  wire type_ready  = !type_det_en || mic_meas_valid_i;
  wire type_value  = type_det_en ? type_meas : cfg7_reg[`CFG7_TYPE_FORCE_BIT];
  wire order_ready = !ordr_det_en || order_meas_valid_i;
  wire order_value = ordr_det_en ? order_meas_i : cfg7_reg[`CFG7_ORDER_FORCE_BIT];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DET_EMPTY: begin
        if (insert_evt) state_next = DET_TYPE;
      end
      DET_TYPE: begin
        if (remove_evt) state_next = DET_EMPTY;
        else if (type_ready) state_next = type_value ? DET_ORDER : DET_DONE;
      end
      DET_ORDER: begin
        if (remove_evt) state_next = DET_EMPTY;
        else if (order_ready) state_next = DET_DONE;
      end
      DET_DONE: begin
        state_next = remove_evt ? DET_EMPTY : DET_HOLD;
      end
      DET_HOLD: begin
        if (remove_evt) state_next = DET_EMPTY;
      end
      default: state_next = DET_EMPTY;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg          <= DET_EMPTY;
      present_seen_reg   <= 1'b0;
      present_reg        <= 1'b0;
      type_reg           <= 1'b0;
      order_reg          <= 1'b0;
      bias_reg           <= 1'b0;
      type_meas_start_o  <= 1'b0;
      order_meas_start_o <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      if (insert_evt || remove_evt) present_seen_reg <= present_now;
      present_reg <= present_now;
      type_meas_start_o  <= insert_evt && type_det_en;
      // 3-pole plugs skip the order step, order stays 0
      order_meas_start_o <= (state_reg == DET_TYPE) && (state_next == DET_ORDER)
                            && ordr_det_en;
      if (remove_evt || insert_evt) begin
        // stale results cleared; software waits for completion anyway
        type_reg  <= 1'b0;
        order_reg <= 1'b0;
        bias_reg  <= 1'b0;
      end else if ((state_reg == DET_TYPE) && type_ready) begin
        type_reg <= type_value;
        bias_reg <= type_value;
      end else if ((state_reg == DET_ORDER) && order_ready) begin
        order_reg <= order_value;
      end
    end
  end

  // ------------------------------------------------------------
  // events and interrupt
  // ------------------------------------------------------------
  logic [`JACK_EVT_W-1:0] jset;
  assign jset = {(state_reg == DET_DONE), remove_evt, insert_evt};

  // a set in the clearing cycle survives
  assign jflag_next = (jflag_reg & ~(wr_jflag ? reg_wdata_i[`JACK_EVT_W-1:0]
                                              : {`JACK_EVT_W{1'b0}})) | jset;
  assign bflag_next = (bflag_reg & ~(wr_bflag ? reg_wdata_i : 8'h00))
                      | button_event_i;

  // registered below so the pin never glitches as flags and masks move
  wire jack_irq_any = |(jflag_reg & ~jmask_reg[`JACK_EVT_W-1:0]);
  wire btn_irq_any  = |(bflag_reg & ~bmask_reg);
  wire irq_next     = jack_irq_any || btn_irq_any;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      jflag_reg <= {`JACK_EVT_W{1'b0}};
      bflag_reg <= `REG_ZERO_RESET;
      imp_reg   <= `REG_ZERO_RESET;
      irq_o     <= 1'b0;
    end else if (ce_i) begin
      jflag_reg <= jflag_next;
      bflag_reg <= bflag_next;
      // last sample stays until the next one, even after removal
      if (adc_valid_i) imp_reg <= adc_sample_i;
      irq_o <= irq_next;
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  reg_byte_t status_main, rd_value, hptest_view;
  assign status_main = {4'h0, bias_reg, order_reg, type_reg, present_reg};
  // comparator bit is live, so a write can never fake it
  assign hptest_view = cfg8_reg | {3'h0, comp_now, 4'h0};

  always_comb begin
    if (reg_addr_i == `ACC_STATUS_MAIN_ADDR)          rd_value = status_main;
    else if (reg_addr_i == `BUTTON_IMP_STATUS_ADDR)   rd_value = imp_reg;
    else if (reg_addr_i == `JACK_EVENT_FLAGS_ADDR)    rd_value = {5'h00, jflag_reg};
    else if (reg_addr_i == `BUTTON_EVENT_FLAGS_ADDR)  rd_value = bflag_reg;
    else if (reg_addr_i == `JACK_EVENT_MASKS_ADDR)    rd_value = jmask_reg;
    else if (reg_addr_i == `BUTTON_EVENT_MASKS_ADDR)  rd_value = bmask_reg;
    else if (reg_addr_i == `DETECT_CONFIG_ONE_ADDR)   rd_value = cfg1_reg;
    else if (reg_addr_i == `DETECT_CONFIG_TWO_ADDR)   rd_value = cfg2_reg;
    else if (reg_addr_i == `BUTTON_THR_FIRST_ADDR)    rd_value = thr1_reg;
    else if (reg_addr_i == `BUTTON_THR_SECOND_ADDR)   rd_value = thr2_reg;
    else if (reg_addr_i == `BUTTON_THR_THIRD_ADDR)    rd_value = thr3_reg;
    else if (reg_addr_i == `BUTTON_THR_MIC_ADDR)      rd_value = thr4_reg;
    else if (reg_addr_i == `DETECT_FORCE_SAMP_ADDR)   rd_value = cfg7_reg;
    else if (reg_addr_i == `HP_TEST_CONTROL_ADDR)     rd_value = hptest_view;
    else                                              rd_value = 8'h00;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      reg_rdata_o      <= 8'h00;
      micbias_en_o     <= 1'b0;
      config_one_o     <= `CONFIG_ONE_RESET;
      config_two_o     <= `REG_ZERO_RESET;
      force_sampling_o <= `REG_ZERO_RESET;
      hptest_ctrl_o    <= `REG_ZERO_RESET;
      thr_first_o      <= `REG_ZERO_RESET;
      thr_second_o     <= `REG_ZERO_RESET;
      thr_third_o      <= `REG_ZERO_RESET;
      thr_mic_o        <= `REG_ZERO_RESET;
    end else if (ce_i) begin
      if (reg_rd_i) reg_rdata_o <= rd_value;
      micbias_en_o     <= bias_reg;
      config_one_o     <= cfg1_reg;
      config_two_o     <= cfg2_reg;
      force_sampling_o <= cfg7_reg;
      hptest_ctrl_o    <= cfg8_reg;
      thr_first_o      <= thr1_reg;
      thr_second_o     <= thr2_reg;
      thr_third_o      <= thr3_reg;
      thr_mic_o        <= thr4_reg;
    end
  end

endmodule

//--- pkg/accdet_pkg.sv
package accdet_pkg;

  typedef enum logic [2:0] {
    DET_EMPTY = 3'b000,
    DET_TYPE  = 3'b001,
    DET_ORDER = 3'b010,
    DET_DONE  = 3'b011,
    DET_HOLD  = 3'b100
  } det_state_t;

  typedef logic [7:0] reg_byte_t;

endpackage

//--- pkg/accdet_regs.svh
`ifndef ACCDET_REGS_SVH
`define ACCDET_REGS_SVH


// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define ACC_STATUS_MAIN_ADDR     8'hc0
`define BUTTON_IMP_STATUS_ADDR   8'hc1
`define JACK_EVENT_FLAGS_ADDR    8'hc2
`define BUTTON_EVENT_FLAGS_ADDR  8'hc3
`define JACK_EVENT_MASKS_ADDR    8'hc4
`define BUTTON_EVENT_MASKS_ADDR  8'hc5
`define DETECT_CONFIG_ONE_ADDR   8'hc6
`define DETECT_CONFIG_TWO_ADDR   8'hc7
`define BUTTON_THR_FIRST_ADDR    8'hc8
`define BUTTON_THR_SECOND_ADDR   8'hc9
`define BUTTON_THR_THIRD_ADDR    8'hca
`define BUTTON_THR_MIC_ADDR      8'hcb
`define DETECT_FORCE_SAMP_ADDR   8'hcc
`define HP_TEST_CONTROL_ADDR     8'hcd

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define STS_PRESENT_BIT     0
`define STS_TYPE_BIT        1
`define STS_ORDER_BIT       2
`define STS_MICBIAS_BIT     3
`define EVT_INSERTED_BIT    0
`define EVT_REMOVED_BIT     1
`define EVT_COMPLETE_BIT    2
`define JACK_EVT_W          3
`define CFG1_ENABLE_BIT     0
`define CFG1_THRESH_LSB     4
`define CFG1_TYPE_DET_BIT   6
`define CFG1_ORDER_DET_BIT  7
`define CFG7_ORDER_FORCE_BIT 4
`define CFG7_TYPE_FORCE_BIT  5
`define CFG8_COMP_BIT       4
`define CFG8_WMASK          8'h07

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CONFIG_ONE_RESET    8'hd0
`define REG_ZERO_RESET      8'h00

// ------------------------------------------------------------
// mic detect thresholds in ohms
// ------------------------------------------------------------
`define MIC_THRESH_200      11'd200
`define MIC_THRESH_500      11'd500
`define MIC_THRESH_750      11'd750
`define MIC_THRESH_1000     11'd1000

`endif

//--- verification/accdet_asserts.sv
`timescale 1ns/1ns
module accdet_asserts #(
  parameter int ADC_W = 8
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic             reg_wr_i,
  input  wire logic [7:0]       reg_wdata_i,
  input  wire logic             reg_rd_i,
  input  wire logic [7:0]       reg_rdata_o,
  input  wire logic             jack_present_i,
  input  wire logic             mic_meas_valid_i,
  input  wire logic             adc_valid_i,
  input  wire logic [ADC_W-1:0] adc_sample_i,
  input  wire logic             micbias_en_o,
  input  wire logic             type_meas_start_o,
  input  wire logic [7:0]       config_one_o,
  input  wire logic             irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_mask_all;
    reg_wr_i && reg_addr_i == 8'hc4 && reg_wdata_i == 8'h07
    ##1 reg_wr_i && reg_addr_i == 8'hc5 && reg_wdata_i == 8'hff;
  endsequence
  sequence s_adc_rd;
    adc_valid_i ##1 !adc_valid_i && reg_rd_i && reg_addr_i == 8'hc1;
  endsequence
  property p_rst_vals;
    $fell(rst_i) |-> config_one_o == 8'hd0 && !irq_o && !micbias_en_o;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad reset outputs");
  property p_sts_res;
    reg_rd_i && reg_addr_i == 8'hc0 |=> reg_rdata_o[7:4] == 4'h0;
  endproperty
  a_sts_res: assert property (p_sts_res) else $error("status high bits set");
  property p_evt_res;
    reg_rd_i && reg_addr_i == 8'hc2 |=> reg_rdata_o[7:3] == 5'h00;
  endproperty
  a_evt_res: assert property (p_evt_res) else $error("event high bits set");
  property p_masked;
    s_mask_all |=> ##1 !irq_o;
  endproperty
  a_masked: assert property (p_masked) else $error("irq while masked");
  property p_adc;
    s_adc_rd |=> reg_rdata_o == $past(adc_sample_i, 2);
  endproperty
  a_adc: assert property (p_adc) else $error("impedance not latched");
  property p_rd_hold;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_bias_rise;
    $rose(micbias_en_o) |-> $past(mic_meas_valid_i, 2) || !config_one_o[6];
  endproperty
  a_bias_rise: assert property (p_bias_rise) else $error("bias without 4-pole");
  property p_bias_off;
    !jack_present_i [*8] |-> !micbias_en_o;
  endproperty
  a_bias_off: assert property (p_bias_off) else $error("bias on, no plug");
  property p_type_start;
    type_meas_start_o |-> config_one_o[6];
  endproperty
  a_type_start: assert property (p_type_start) else $error("type run disabled");
endmodule

//--- verification/accessory_detect_status_irq_bench.sv
`timescale 1ns/1ns
module accessory_detect_status_irq_bench;
  import accdet_pkg::*;
  typedef struct {reg_byte_t a, w, e;} row_t;
  typedef struct {reg_byte_t cfg, frc; logic [10:0] imp; logic ord; reg_byte_t st;} det_t;
  logic        mclk_i, rst_i, reg_wr_i, reg_rd_i, adc_valid_i, hptest_comp_i;
  logic [7:0]  reg_addr_i, reg_wdata_i, adc_sample_i, button_event_i, reg_rdata_o;
  logic        jack_present_i, mic_meas_valid_i, order_meas_valid_i, order_meas_i;
  logic [10:0] mic_impedance_i, pimp;
  logic        micbias_en_o, type_meas_start_o, order_meas_start_o, irq_o, plugged, pord;
  logic        ce_i;
  reg_byte_t   cfg1_q, cfg2_q, frc_q, hpt_q, thr1_q, thr2_q, thr3_q, thr4_q;
  logic [3:0]  plat;
  int          n_fail, tests_run, cyc;
  reg_byte_t   rv;
  row_t rows [12] = '{'{8'hc4, 8'hff, 8'h07}, '{8'hc5, 8'ha5, 8'ha5}, '{8'hc7, 8'h3c, 8'h3c},
    '{8'hc8, 8'h11, 8'h11}, '{8'hc9, 8'h22, 8'h22}, '{8'hca, 8'h33, 8'h33},
    '{8'hcb, 8'h44, 8'h44}, '{8'hcd, 8'hff, 8'h17}, '{8'hc0, 8'hff, 8'h00},
    '{8'hc1, 8'hff, 8'h00}, '{8'hce, 8'hff, 8'h00}, '{8'hc3, 8'h00, 8'h00}};
  det_t dets [8] = '{'{8'hd1, 8'h00, 11'd800, 1, 8'h0f}, '{8'hd1, 8'h00, 11'd500, 1, 8'h01},
    '{8'hf1, 8'h00, 11'd800, 1, 8'h01}, '{8'hc1, 8'h00, 11'd201, 0, 8'h0b},
    '{8'h51, 8'h10, 11'd800, 0, 8'h0f}, '{8'h11, 8'h20, 11'd100, 1, 8'h0b},
    '{8'h01, 8'h00, 11'd900, 1, 8'h01}, '{8'he1, 8'h00, 11'd751, 0, 8'h0b}};

  accessory_detect_status_irq #(.ADC_W(8)) DUT (
    .mclk_i, .rst_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
    .reg_rdata_o, .jack_present_i, .hptest_comp_i, .mic_meas_valid_i, .mic_impedance_i,
    .order_meas_valid_i, .order_meas_i, .adc_valid_i, .adc_sample_i, .button_event_i,
    .micbias_en_o, .type_meas_start_o, .order_meas_start_o, .config_one_o(cfg1_q),
    .config_two_o(cfg2_q), .force_sampling_o(frc_q), .hptest_ctrl_o(hpt_q),
    .thr_first_o(thr1_q), .thr_second_o(thr2_q), .thr_third_o(thr3_q),
    .thr_mic_o(thr4_q), .irq_o);
  headset_plug_model plug (
    .mclk_i, .plugged_i(plugged), .imp_i(pimp), .order_i(pord), .lat_i(plat),
    .type_start_i(type_meas_start_o), .order_start_i(order_meas_start_o),
    .present_o(jack_present_i), .mic_valid_o(mic_meas_valid_i),
    .mic_imp_o(mic_impedance_i), .order_valid_o(order_meas_valid_i), .order_o(order_meas_i));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // every call drives all strobes once, so no signal is set twice in a step
  task automatic bus(logic w, logic r, reg_byte_t a, reg_byte_t d);
    reg_wr_i = w;
    reg_rd_i = r;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(reg_byte_t a, reg_byte_t d);
    bus(1, 0, a, d);
    bus(0, 0, a, d);
  endtask
  task automatic rdc(reg_byte_t a, reg_byte_t e);
    bus(0, 1, a, 8'h00);
    bus(0, 0, a, 8'h00);
    chk($sformatf("reg %h", a), e, reg_rdata_o);
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wait_done();
    rv = 8'h00;
    for (int k = 0; k < 40 && !rv[2]; k++) begin
      bus(0, 1, 8'hc2, 8'h00);
      bus(0, 0, 8'hc2, 8'h00);
      rv = reg_rdata_o;
    end
  endtask

  initial begin
    mclk_i = 0;
    forever #2 mclk_i = ~mclk_i;
  end
  // ceiling well above the longest detection sweep
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      finish_test();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reg_wr_i, reg_rd_i, adc_valid_i, hptest_comp_i, plugged, pord} = '0;
    {reg_addr_i, reg_wdata_i, adc_sample_i, button_event_i} = '0;
    pimp = 11'd0;
    plat = 4'h0;
    ce_i = 1;
    rst_i = 1;
    repeat (6) @(posedge mclk_i);
    #1 rst_i = 0;
    for (int i = 0; i < 15; i++) rdc(8'(8'hc0 + i), i == 6 ? 8'hd0 : 8'h00);
    hptest_comp_i = 1;
    idle(6);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdc(rows[i].a, rows[i].e);
    end
    chk("cfg2 out", 8'h3c, cfg2_q);
    chk("hptest out", 8'h07, hpt_q);
    chk("thr1 out", 8'h11, thr1_q);
    chk("thr2 out", 8'h22, thr2_q);
    chk("thr3 out", 8'h33, thr3_q);
    chk("thr4 out", 8'h44, thr4_q);
    ce_i = 0;
    wr(8'hc7, 8'h55);
    ce_i = 1;
    rdc(8'hc7, 8'h3c);
    wr(8'hc4, 8'h00);
    wr(8'hc5, 8'h00);
    foreach (dets[i]) begin
      wr(8'hc6, dets[i].cfg);
      wr(8'hcc, dets[i].frc);
      {pimp, pord, plat, plugged} = {dets[i].imp, dets[i].ord, i[0] ? 4'h9 : 4'h0, 1'b1};
      wait_done();
      rdc(8'hc0, dets[i].st);
      chk("micbias", {7'h0, dets[i].st[3]}, {7'h0, micbias_en_o});
      chk("cfg1 out", dets[i].cfg, cfg1_q);
      chk("force out", dets[i].frc, frc_q);
      chk("irq", 8'h01, {7'h0, irq_o});
      rdc(8'hc2, 8'h05);
      plugged = 0;
      idle(12);
      rdc(8'hc0, 8'h00);
      rdc(8'hc2, 8'h07);
      wr(8'hc2, 8'h07);
      rdc(8'hc2, 8'h00);
      chk("irq", 8'h00, {7'h0, irq_o});
    end
    wr(8'hc6, 8'hd0);
    plugged = 1;
    idle(15);
    rdc(8'hc2, 8'h00);
    wr(8'hc6, 8'hd1);
    wait_done();
    wr(8'hc2, 8'h00);
    rdc(8'hc2, 8'h05);
    bus(1, 0, 8'hc4, 8'h07);
    bus(1, 0, 8'hc5, 8'hff);
    bus(0, 0, 8'h00, 8'h00);
    chk("irq", 8'h00, {7'h0, irq_o});
    wr(8'hc4, 8'h03);
    idle(2);
    chk("irq", 8'h01, {7'h0, irq_o});
    wr(8'hc2, 8'h01);
    rdc(8'hc2, 8'h04);
    wr(8'hc2, 8'h04);
    rdc(8'hc2, 8'h00);
    chk("irq", 8'h00, {7'h0, irq_o});
    button_event_i = 8'h81;
    idle(1);
    button_event_i = 8'h00;
    rdc(8'hc3, 8'h81);
    chk("irq", 8'h00, {7'h0, irq_o});
    wr(8'hc5, 8'h7f);
    idle(2);
    chk("irq", 8'h01, {7'h0, irq_o});
    wr(8'hc3, 8'h81);
    rdc(8'hc3, 8'h00);
    adc_valid_i = 1;
    adc_sample_i = 8'ha7;
    bus(0, 0, 8'h00, 8'h00);
    adc_valid_i = 0;
    adc_sample_i = 8'h58;
    rdc(8'hc1, 8'ha7);
    finish_test();
  end
endmodule

bind accessory_detect_status_irq accdet_asserts #(.ADC_W(ADC_W)) u_chk (
  .mclk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
  .jack_present_i, .mic_meas_valid_i, .adc_valid_i, .adc_sample_i, .micbias_en_o,
  .type_meas_start_o, .config_one_o, .irq_o);

//--- verification/headset_plug_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// plug in the jack, answers measurements
// ----------------------------------------
module headset_plug_model (
  input  wire logic        mclk_i,
  input  wire logic        plugged_i,
  input  wire logic [10:0] imp_i,
  input  wire logic        order_i,
  input  wire logic [3:0]  lat_i,
  input  wire logic        type_start_i,
  input  wire logic        order_start_i,
  output logic             present_o,
  output logic             mic_valid_o,
  output logic [10:0]      mic_imp_o,
  output logic             order_valid_o,
  output logic             order_o
);
  int tcnt = -1;
  int ocnt = -1;
  initial begin
    present_o = 0;
    mic_valid_o = 0;
    mic_imp_o = 11'h155;
    order_valid_o = 0;
    order_o = 0;
  end
  // lat_i 0 answers promptly, larger values stall
  always @(posedge mclk_i) begin
    present_o <= plugged_i;
    tcnt <= type_start_i ? int'(lat_i) : (tcnt >= 0 ? tcnt - 1 : -1);
    ocnt <= order_start_i ? int'(lat_i) : (ocnt >= 0 ? ocnt - 1 : -1);
    mic_valid_o <= (tcnt == 0);
    // off-pulse values toggle so stale data never looks valid
    mic_imp_o <= (tcnt == 0) ? imp_i : ~mic_imp_o;
    order_valid_o <= (ocnt == 0);
    order_o <= (ocnt == 0) ? order_i : ~order_o;
  end
endmodule
